// ===== src/sync_period_timer_map.vh
// constants shared by the period timer pair: widths, reset values, prescale codes
`ifndef SYNC_PERIOD_TIMER_MAP_VH
`define SYNC_PERIOD_TIMER_MAP_VH

// count and period widths
`define HALF_W          16
`define FULL_W          32
`define HALF_ZERO       16'h0000
`define HALF_ONE        16'h0001
`define FULL_ZERO       32'h00000000
`define FULL_ONE        32'h00000001

// prescale select codes (3-bit field)
`define PS_SEL_W        3
`define PS_DIV1         3'h0
`define PS_DIV2         3'h1
`define PS_DIV4         3'h2
`define PS_DIV8         3'h3
`define PS_DIV16        3'h4
`define PS_DIV32        3'h5
`define PS_DIV64        3'h6
`define PS_DIV256       3'h7

// prescale counter: last count value for each division (N - 1)
`define PS_CNT_W        8
`define PS_CNT_ZERO     8'h00
`define PS_CNT_ONE      8'h01
`define PS_LAST_DIV1    8'h00
`define PS_LAST_DIV2    8'h01
`define PS_LAST_DIV4    8'h03
`define PS_LAST_DIV8    8'h07
`define PS_LAST_DIV16   8'h0f
`define PS_LAST_DIV32   8'h1f
`define PS_LAST_DIV64   8'h3f
`define PS_LAST_DIV256  8'hff

`endif

// ===== src/prescale_tick.v
// prescaler: divides the bus clock into one-cycle timer clock ticks
`timescale 1ns/100ps
`default_nettype none
`include "sync_period_timer_map.vh"

module prescale_tick (
	input  wire                   ref_clk_i,
	input  wire                   reset_i,
	input  wire                   run_i,
	input  wire [`PS_SEL_W-1:0]   psel_i,
	output wire                   tick_o
);

	reg  [`PS_CNT_W-1:0] div_cnt_r;
	wire [`PS_CNT_W-1:0] div_last;

	// =========================================================
	// division decode
	function [`PS_CNT_W-1:0] last_count;
		input [`PS_SEL_W-1:0] sel;
		begin
			case (sel)
				`PS_DIV1:   last_count = `PS_LAST_DIV1;
				`PS_DIV2:   last_count = `PS_LAST_DIV2;
				`PS_DIV4:   last_count = `PS_LAST_DIV4;
				`PS_DIV8:   last_count = `PS_LAST_DIV8;
				`PS_DIV16:  last_count = `PS_LAST_DIV16;
				`PS_DIV32:  last_count = `PS_LAST_DIV32;
				`PS_DIV64:  last_count = `PS_LAST_DIV64;
				default:    last_count = `PS_LAST_DIV256;
			endcase
		end
	endfunction

	assign div_last = last_count(psel_i);
	// 1:1 gives a tick on every edge; N gives one per N edges
	assign tick_o   = run_i & (div_cnt_r == div_last);

	// =========================================================
	// divider counter, cleared while stopped so a restart waits a full N
	always @(posedge ref_clk_i) begin
		if (reset_i || !run_i || tick_o) begin
			div_cnt_r <= `PS_CNT_ZERO;
		end else begin
			div_cnt_r <= div_cnt_r + `PS_CNT_ONE;
		end
	end

endmodule // prescale_tick

`default_nettype wire

// ===== src/irq_flag_cell.v
// sticky interrupt flag with clear port and enable-gated request
`timescale 1ns/100ps
`default_nettype none

module irq_flag_cell (
	input  wire ref_clk_i,
	input  wire reset_i,
	input  wire set_i,
	input  wire clr_i,
	input  wire irq_enable_i,
	output reg  flag_o,
	output reg  irq_o
);

	// =========================================================
	// flag: a set in the clear cycle wins so no event is lost
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			flag_o <= 1'b0;
		end else if (set_i) begin
			flag_o <= 1'b1;
		end else if (clr_i) begin
			flag_o <= 1'b0;
		end
	end

	// request only while the enable is set
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= flag_o & irq_enable_i;
		end
	end

endmodule // irq_flag_cell

`default_nettype wire

// ===== src/sync_period_timer.v
// period-match timer pair: two 16-bit timers that can join into one 32-bit timer
`timescale 1ns/100ps
`default_nettype none
`include "sync_period_timer_map.vh"

module sync_period_timer (
	input  wire                  ref_clk_i,
	input  wire                  reset_i,
	// even (master) timer control
	input  wire                  even_on_i,
	input  wire                  even_clk_source_sel_i,
	input  wire                  pair_mode_sel_i,
	input  wire [`PS_SEL_W-1:0]  even_psel_i,
	// odd (slave) timer control, ignored while paired
	input  wire                  odd_on_i,
	input  wire                  odd_clk_source_sel_i,
	input  wire [`PS_SEL_W-1:0]  odd_psel_i,
	// count and period loads
	input  wire                  even_count_wr_i,
	input  wire                  odd_count_wr_i,
	input  wire                  even_period_wr_i,
	input  wire                  odd_period_wr_i,
	input  wire [`HALF_W-1:0]    even_wdata_i,
	input  wire [`HALF_W-1:0]    odd_wdata_i,
	// interrupt flag clears and enables
	input  wire                  timer_irq_clr_i,
	input  wire                  partner_irq_clr_i,
	input  wire                  timer_irq_enable_i,
	input  wire                  partner_irq_enable_i,
	// state
	output reg  [`HALF_W-1:0]    even_count_value_o,
	output reg  [`HALF_W-1:0]    odd_count_value_o,
	output reg  [`HALF_W-1:0]    even_period_value_o,
	output reg  [`HALF_W-1:0]    odd_period_value_o,
	output reg                   even_event_o,
	output reg                   odd_event_o,
	output wire                  timer_irq_flag_o,
	output wire                  partner_irq_flag_o,
	output wire                  timer_irq_o,
	output wire                  partner_irq_o
);

	// =========================================================
	// declarations
	wire                 paired;
	wire                 even_run;
	wire                 odd_run_own;
	wire                 odd_run;
	wire                 even_tick;
	wire                 odd_tick_own;
	wire                 odd_tick;
	wire [`FULL_W-1:0]   comb_count;
	wire [`FULL_W-1:0]   comb_period;
	reg  [`FULL_W-1:0]   comb_count_nxt;
	reg  [`HALF_W-1:0]   even_count_nxt;
	reg  [`HALF_W-1:0]   odd_count_nxt;
	wire                 even_match;
	wire                 odd_match;
	reg                  even_match_r;
	reg                  odd_match_r;
	wire                 even_match_new;
	wire                 odd_match_new;
	reg                  even_irq_set_r;
	reg                  odd_irq_set_r;
	wire                 even_period_nonzero;
	wire                 odd_period_nonzero;
	wire                 comb_period_nonzero;

	// =========================================================
	// helpers
	// next value of a 16-bit count on a timer clock tick
	function [`HALF_W-1:0] half_step;
		input [`HALF_W-1:0] cnt;
		input [`HALF_W-1:0] per;
		begin
			// a zero period forces the wrap even from a loaded count
			if ((cnt == per) || (per == `HALF_ZERO)) begin
				half_step = `HALF_ZERO;
			end else begin
				half_step = cnt + `HALF_ONE;
			end
		end
	endfunction

	// next value of the combined 32-bit count on a timer clock tick
	function [`FULL_W-1:0] full_step;
		input [`FULL_W-1:0] cnt;
		input [`FULL_W-1:0] per;
		begin
			// a zero combined period forces the wrap from any loaded count
			if ((cnt == per) || (per == `FULL_ZERO)) begin
				full_step = `FULL_ZERO;
			end else begin
				full_step = cnt + `FULL_ONE;
			end
		end
	endfunction

	// =========================================================
	// mode and run decode
	// only the even timer's pair bit forms the pair
	assign paired      = pair_mode_sel_i;
	// source select low means bus clock; high would be the external counter,
	// which this block does not carry, so the timer simply does not advance
	assign even_run    = even_on_i & ~even_clk_source_sel_i;
	assign odd_run_own = odd_on_i & ~odd_clk_source_sel_i & ~paired;
	// odd half follows the even controls while paired
	assign odd_run     = paired ? even_run : odd_run_own;

	// =========================================================
	// prescalers; timer clock is the bus clock itself, so no
	// synchroniser is needed and any sync select has nothing to do
	// the odd divider idles while paired, so unpairing restarts it clean
	prescale_tick u_even_ps (
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.run_i     (even_run),
		.psel_i    (even_psel_i),
		.tick_o    (even_tick)
	);

	prescale_tick u_odd_ps (
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.run_i     (odd_run_own),
		.psel_i    (odd_psel_i),
		.tick_o    (odd_tick_own)
	);

	// paired: both halves move on the even timer's tick
	assign odd_tick = paired ? even_tick : odd_tick_own;

	// =========================================================
	// combined view: even is the low half, odd the high half
	assign comb_count  = {odd_count_value_o, even_count_value_o};
	assign comb_period = {odd_period_value_o, even_period_value_o};

	// =========================================================
	// count next-state
	// loads win over counting; software should load only while stopped
	always @* begin
		comb_count_nxt = full_step(comb_count, comb_period);
		even_count_nxt = even_count_value_o;
		odd_count_nxt  = odd_count_value_o;
		// paired: one 32-bit step on the even tick, split into halves
		if (paired) begin
			if (even_tick) begin
				even_count_nxt = comb_count_nxt[`HALF_W-1:0];
				odd_count_nxt  = comb_count_nxt[`FULL_W-1:`HALF_W];
			end
		end else begin
			// split: each half steps on its own timer clock
			if (even_tick) begin
				even_count_nxt = half_step(even_count_value_o, even_period_value_o);
			end
			if (odd_tick) begin
				odd_count_nxt = half_step(odd_count_value_o, odd_period_value_o);
			end
		end
		// loads come last so that a load beats a tick in the same cycle
		if (even_count_wr_i) begin
			even_count_nxt = even_wdata_i;
		end
		if (odd_count_wr_i) begin
			odd_count_nxt = odd_wdata_i;
		end
	end

	// =========================================================
	// count registers; hold whenever neither a tick nor a load arrives
	// even half: low half of the pair
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			even_count_value_o <= `HALF_ZERO;
		end else begin
			even_count_value_o <= even_count_nxt;
		end
	end

	// odd half: high half of the pair, or its own 16-bit count
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			odd_count_value_o <= `HALF_ZERO;
		end else begin
			odd_count_value_o <= odd_count_nxt;
		end
	end

	// =========================================================
	// period registers; any value up to all ones is taken
	// a write while running can skip past the count and cause a late or
	// spurious match, which is why software is told to write while stopped
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			even_period_value_o <= `HALF_ZERO;
		end else if (even_period_wr_i) begin
			even_period_value_o <= even_wdata_i;
		end
	end

	// odd period: high half of the combined period while paired
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			odd_period_value_o <= `HALF_ZERO;
		end else if (odd_period_wr_i) begin
			odd_period_value_o <= odd_wdata_i;
		end
	end

	// =========================================================
	// match detection
	// the even match stands only in 16-bit mode; paired, the odd side
	// carries the combined match
	assign even_match = ~paired & even_run &
		(even_count_value_o == even_period_value_o);
	assign odd_match  = paired ?
		(even_run & (comb_count == comb_period)) :
		(odd_run & (odd_count_value_o == odd_period_value_o));

	// only a fresh match makes an event; a zero period that holds the
	// count at its match would otherwise fire on every clock
	assign even_match_new = even_match & ~even_match_r;
	assign odd_match_new  = odd_match & ~odd_match_r;

	// a zero period still matches but must not raise a flag
	assign even_period_nonzero = (even_period_value_o != `HALF_ZERO);
	assign odd_period_nonzero  = (odd_period_value_o != `HALF_ZERO);
	assign comb_period_nonzero = (comb_period != `FULL_ZERO);

	// even match history for the edge detector
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			even_match_r <= 1'b0;
		end else begin
			even_match_r <= even_match;
		end
	end

	// odd match history; paired it follows the combined match
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			odd_match_r <= 1'b0;
		end else begin
			odd_match_r <= odd_match;
		end
	end

	// =========================================================
	// timer events: one-cycle pulse one clock after the match, launched on
	// the rising edge; the single-timer half-clock variant is not carried
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			even_event_o <= 1'b0;
		end else begin
			even_event_o <= even_match_new;
		end
	end

	// odd event carries the combined match while paired
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			odd_event_o <= 1'b0;
		end else begin
			odd_event_o <= odd_match_new;
		end
	end

	// =========================================================
	// flag set requests, gated against a zero period
	// the even flag is never set while paired
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			even_irq_set_r <= 1'b0;
		end else begin
			even_irq_set_r <= even_match_new & even_period_nonzero;
		end
	end

	// odd request: the combined period decides while paired
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			odd_irq_set_r <= 1'b0;
		end else begin
			odd_irq_set_r <= odd_match_new &
				(paired ? comb_period_nonzero : odd_period_nonzero);
		end
	end

	// =========================================================
	// interrupt flags: set one clock after the event
	// a set that meets a clear in one cycle wins inside the flag cell
	irq_flag_cell u_even_flag (
		.ref_clk_i    (ref_clk_i),
		.reset_i      (reset_i),
		.set_i        (even_irq_set_r),
		.clr_i        (timer_irq_clr_i),
		.irq_enable_i (timer_irq_enable_i),
		.flag_o       (timer_irq_flag_o),
		.irq_o        (timer_irq_o)
	);

	irq_flag_cell u_odd_flag (
		.ref_clk_i    (ref_clk_i),
		.reset_i      (reset_i),
		.set_i        (odd_irq_set_r),
		.clr_i        (partner_irq_clr_i),
		.irq_enable_i (partner_irq_enable_i),
		.flag_o       (partner_irq_flag_o),
		.irq_o        (partner_irq_o)
	);

endmodule // sync_period_timer

`default_nettype wire

// ===== dv/sync_period_timer_monitor.sv
// assertion checker for the period timer pair, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module sync_period_timer_monitor (
	input wire logic        ref_clk_i,
	input wire logic        reset_i,
	input wire logic        even_on_i,
	input wire logic        even_clk_source_sel_i,
	input wire logic        pair_mode_sel_i,
	input wire logic [2:0]  even_psel_i,
	input wire logic        even_count_wr_i,
	input wire logic        odd_count_wr_i,
	input wire logic        even_period_wr_i,
	input wire logic        odd_period_wr_i,
	input wire logic [15:0] even_count_value_o,
	input wire logic [15:0] odd_count_value_o,
	input wire logic [15:0] even_period_value_o,
	input wire logic [15:0] odd_period_value_o,
	input wire logic        even_event_o,
	input wire logic        odd_event_o,
	input wire logic        timer_irq_flag_o,
	input wire logic        partner_irq_flag_o,
	input wire logic        timer_irq_enable_i,
	input wire logic        timer_irq_o
);
	// ==========================================================
	// match detection
	// loads are excluded so a write never looks like counting
	wire [31:0] cnt  = {odd_count_value_o, even_count_value_o};
	wire [31:0] per  = {odd_period_value_o, even_period_value_o};
	wire        nowr = !(even_count_wr_i | odd_count_wr_i | even_period_wr_i | odd_period_wr_i);
	wire        run  = even_on_i && !even_clk_source_sel_i && nowr && even_psel_i == 3'h0;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	// on is required for two edges since the tick may lag the enable
	sequence s_m16;
		run && $past(even_on_i) && !pair_mode_sel_i
		&& even_count_value_o == even_period_value_o && even_period_value_o != 16'h0000;
	endsequence
	sequence s_m32;
		run && $past(even_on_i) && pair_mode_sel_i && cnt == per && per != 32'h00000000;
	endsequence
	property p_wrap16;
		s_m16 |=> even_count_value_o == 16'h0000 && even_event_o;
	endproperty
	a_wrap16: assert property (p_wrap16) else $error("count did not wrap with event");
	property p_flag16;
		s_m16 |-> ##[1:2] timer_irq_flag_o;
	endproperty
	a_flag16: assert property (p_flag16) else $error("timer flag late");
	property p_wrap32;
		s_m32 |=> cnt == 32'h00000000;
	endproperty
	a_wrap32: assert property (p_wrap32) else $error("combined count did not wrap");
	property p_event32;
		s_m32 |=> odd_event_o;
	endproperty
	a_event32: assert property (p_event32) else $error("combined match gave no event");
	property p_flag32;
		s_m32 |-> ##[1:2] partner_irq_flag_o;
	endproperty
	a_flag32: assert property (p_flag32) else $error("partner flag late");
	property p_hold;
		!even_on_i && !$past(even_on_i) && nowr |=> $stable(even_count_value_o);
	endproperty
	a_hold: assert property (p_hold) else $error("count moved while disabled");
	property p_zero;
		!pair_mode_sel_i && even_event_o && even_period_value_o == 16'h0000
		&& !timer_irq_flag_o |=> !timer_irq_flag_o;
	endproperty
	a_zero: assert property (p_zero) else $error("flag from zero period");
	property p_even_quiet;
		pair_mode_sel_i && !timer_irq_flag_o |=> !timer_irq_flag_o;
	endproperty
	a_even_quiet: assert property (p_even_quiet) else $error("even flag set while paired");
	property p_irq;
		1'b1 |=> timer_irq_o == $past(timer_irq_flag_o && timer_irq_enable_i);
	endproperty
	a_irq: assert property (p_irq) else $error("request not flag and enable");
endmodule // sync_period_timer_monitor
bind sync_period_timer sync_period_timer_monitor i_sync_period_timer_monitor (.*);
`default_nettype wire

// ===== dv/test_sync_period_timer.sv
// self-checking bench for the period timer pair
`timescale 1ns/100ps
`default_nettype none
module test_sync_period_timer;
	logic        clk = 1'b0, rst = 1'b1, on = 1'b0, src = 1'b0, pm = 1'b0;
	logic        cw = 1'b0, pw = 1'b0, clr = 1'b0, ten = 1'b0, pen = 1'b0, oon = 1'b0;
	logic [2:0]  ps = 3'h0;
	logic [15:0] ewd = 16'h0000, owd = 16'h0000;
	logic [31:0] held;
	wire  [15:0] ec, oc, ep, op;
	wire         ee, oe, tf, pf, ti, pi;
	wire  [31:0] cnt = {oc, ec};
	integer      failures = 0, tests_run = 0, n, k;
	int          div [8] = '{1, 2, 4, 8, 16, 32, 64, 256};
	// odd timer runs alone at 1:2 while oon is set; paired mode must ignore it
	sync_period_timer i_sync_period_timer (
		.ref_clk_i(clk), .reset_i(rst), .even_on_i(on), .even_clk_source_sel_i(src),
		.pair_mode_sel_i(pm), .even_psel_i(ps), .odd_on_i(oon), .odd_clk_source_sel_i(1'b0),
		.odd_psel_i(3'h1), .even_count_wr_i(cw), .odd_count_wr_i(cw), .even_period_wr_i(pw),
		.odd_period_wr_i(pw), .even_wdata_i(ewd), .odd_wdata_i(owd), .timer_irq_clr_i(clr),
		.partner_irq_clr_i(clr), .timer_irq_enable_i(ten), .partner_irq_enable_i(pen),
		.even_count_value_o(ec), .odd_count_value_o(oc), .even_period_value_o(ep),
		.odd_period_value_o(op), .even_event_o(ee), .odd_event_o(oe), .timer_irq_flag_o(tf),
		.partner_irq_flag_o(pf), .timer_irq_o(ti), .partner_irq_o(pi));
	// ==========================================================
	// tasks
	always #25 clk = ~clk;
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// stop, let in-flight events settle, load both halves, clear flags, start
	task automatic cfg(input logic m, input logic [2:0] p, input logic [31:0] c, input logic [31:0] q);
		on = 1'b0;
		repeat (4) @(negedge clk);
		pm = m;
		ps = p;
		{owd, ewd} = c;
		cw = 1'b1;
		@(negedge clk);
		cw = 1'b0;
		{owd, ewd} = q;
		pw = 1'b1;
		@(negedge clk);
		pw = 1'b0;
		clr = 1'b1;
		@(negedge clk);
		clr = 1'b0;
		chk("count load", cnt, c);
		chk("period load", {op, ep}, q);
		on = 1'b1;
	endtask
	// bounded wait for a count value; n holds the cycles it took
	task automatic upto(input logic [31:0] v);
		n = 0;
		while (cnt !== v && n < 600) begin
			@(negedge clk);
			n++;
		end
		chk("count reached", cnt, v);
	endtask
	initial begin
		#1000000;
		failures++;
		give_verdict();
	end
	// ==========================================================
	// scenarios
	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		ten = 1'b1;
		cfg(1'b0, 3'h0, 32'h0, 32'h2);
		upto(32'h2);
		@(negedge clk);
		chk("wrap", cnt, 32'h0);
		chk("event", ee, 1'b1);
		@(negedge clk);
		chk("flag", tf, 1'b1);
		@(negedge clk);
		chk("request", ti, 1'b1);
		ten = 1'b0;
		upto(32'h1);
		clr = 1'b1;
		@(negedge clk);
		clr = 1'b0;
		chk("flag clear", tf, 1'b0);
		repeat (3) @(negedge clk);
		chk("flag again", tf, 1'b1);
		chk("masked", ti, 1'b0);
		// every prescale code: gap of each step and of the wrap
		for (k = 0; k < 8; k++) begin
			cfg(1'b0, k[2:0], 32'h0, 32'h1);
			upto(32'h1);
			upto(32'h0);
			chk("wrap gap", n, div[k]);
			upto(32'h1);
			chk("tick gap", n, div[k]);
		end
		cfg(1'b0, 3'h0, 32'hfffd, 32'hffff);
		upto(32'hffff);
		@(negedge clk);
		chk("max wrap", cnt, 32'h0);
		upto(32'h5);
		on = 1'b0;
		@(negedge clk);
		held = cnt;
		repeat (5) @(negedge clk);
		chk("hold off", cnt, held);
		on = 1'b1;
		src = 1'b1;
		@(negedge clk);
		held = cnt;
		repeat (5) @(negedge clk);
		chk("hold source", cnt, held);
		src = 1'b0;
		cfg(1'b0, 3'h0, 32'h5, 32'h0);
		repeat (20) @(negedge clk);
		chk("zero hold", cnt, 32'h0);
		chk("zero flag", tf, 1'b0);
		// odd timer alone at 1:2 while the even one holds at a zero period
		cfg(1'b0, 3'h0, 32'h0, 32'h00020000);
		oon = 1'b1;
		upto(32'h00020000);
		upto(32'h0);
		chk("odd wrap gap", n, 32'h2);
		chk("odd flag", pf, 1'b1);
		chk("even zero flag", tf, 1'b0);
		// paired: carry across halves, partner flag only; odd on is ignored
		pen = 1'b1;
		cfg(1'b1, 3'h0, 32'h0000fffe, 32'h00010001);
		upto(32'h00010000);
		upto(32'h00010001);
		@(negedge clk);
		chk("pair wrap", cnt, 32'h0);
		chk("pair event", oe, 1'b1);
		chk("even event", ee, 1'b0);
		@(negedge clk);
		chk("partner flag", pf, 1'b1);
		chk("even flag", tf, 1'b0);
		@(negedge clk);
		chk("partner request", pi, 1'b1);
		cfg(1'b1, 3'h3, 32'h0, 32'h1);
		upto(32'h1);
		upto(32'h0);
		chk("pair gap", n, 32'h8);
		cfg(1'b1, 3'h0, 32'h00030000, 32'h0);
		repeat (20) @(negedge clk);
		chk("pair zero", cnt, 32'h0);
		chk("pair zero flag", pf, 1'b0);
		give_verdict();
	end
endmodule // test_sync_period_timer
`default_nettype wire
